// ===== core/scro_core.sv
// execution of pop, push, relative call, software reset and no-operation
// Behaviour
// - pop discards top entry, one cycle
// - push writes pc plus two, entries deepen up to 31
// - push one cycle, stack write in Q2
// - call 11011 prefix, 11-bit offset, two cycles
// - call pushes return, pc gets return+2n
// - offset signed, -1024 to +1023 words
// - software reset equals master-clear reset
// - software reset starts in Q2, one word
`timescale 1ns/1ps
`include "scro_defs.svh"

module scro_core
(
    input  wire logic                   ref_clk_i,
    input  wire logic                   rst_b_i,
    input  wire logic                   master_clear_input_b_i,
    input  wire logic [15:0]            instr_i,
    input  wire logic                   instr_valid_i,
    output logic                        instr_ready_o,
    output logic [`SCRO_PC_W-1:0]       pc_o,
    output logic [`SCRO_PC_W-1:0]       stack_top_entry_o,
    output logic [`SCRO_PTR_W-1:0]      stack_depth_o,
    output logic [1:0]                  quarter_o,
    output logic                        core_reset_o,
    output logic                        retired_o
);

    // ==========================================================
    // decode
    function automatic scro_pkg::scro_dec_t scro_decode(input logic [15:0] w);
        scro_pkg::scro_dec_t d;
        d.offset = w[`SCRO_OFS_W-1:0];
        if (w[`SCRO_CALL_MSB:`SCRO_CALL_LSB] == `SCRO_CALL_CODE)
            d.kind = scro_pkg::SCRO_K_CALL;
        else if (w == `SCRO_OP_POP)
            d.kind = scro_pkg::SCRO_K_POP;
        else if (w == `SCRO_OP_PUSH)
            d.kind = scro_pkg::SCRO_K_PUSH;
        else if (w == `SCRO_OP_SWRST)
            d.kind = scro_pkg::SCRO_K_RST;
        else if (w == `SCRO_OP_ZERO || w[15:12] == `SCRO_NOP_CODE)
            d.kind = scro_pkg::SCRO_K_NOP;
        else
            d.kind = scro_pkg::SCRO_K_OTHER;
        return d;
    endfunction : scro_decode

    // sign-extend the 11-bit word offset and double it
    function automatic logic [`SCRO_PC_W-1:0] scro_rel(input logic [10:0] n);
        return {{(`SCRO_PC_W-12){n[10]}}, n, 1'b0};
    endfunction : scro_rel

    scro_pkg::scro_state_t   state_r;
    scro_pkg::scro_state_t   state_nxt;
    logic [1:0]              q_r;
    logic [1:0]              q_nxt;
    logic [15:0]             ir_r;
    logic [15:0]             ir_nxt;
    logic [`SCRO_PC_W-1:0]   pc_r;
    logic [`SCRO_PC_W-1:0]   pc_nxt;
    logic                    ready_r;
    logic                    ready_nxt;
    logic                    rst_out_r;
    logic                    rst_out_nxt;
    logic                    ret_r;
    logic                    ret_nxt;
    scro_pkg::scro_dec_t     dec;
    scro_pkg::scro_stk_cmd_t stk_cmd;
    logic                    stk_clr;
    logic [`SCRO_PC_W-1:0]   stk_top;
    logic [`SCRO_PTR_W-1:0]  stk_depth;
    logic [`SCRO_PC_W-1:0]   top_r;
    logic [`SCRO_PTR_W-1:0]  depth_r;

    assign dec = scro_decode(ir_r);

    // ==========================================================
    // sequencing: four quarters per instruction cycle
    always_comb
    begin
        state_nxt   = state_r;
        q_nxt       = q_r + 2'h1;
        ir_nxt      = ir_r;
        pc_nxt      = pc_r;
        ready_nxt   = 1'b0;
        rst_out_nxt = 1'b0;
        ret_nxt     = 1'b0;
        stk_cmd     = '0;
        stk_clr     = 1'b0;
        unique case (state_r)
            scro_pkg::SCRO_ST_IDLE:
            begin
                q_nxt     = 2'h0;
                ready_nxt = 1'b1;
                if (instr_valid_i && ready_r)
                begin
                    ir_nxt    = instr_i;
                    ready_nxt = 1'b0;
                    state_nxt = scro_pkg::SCRO_ST_EXEC;
                end
            end
            scro_pkg::SCRO_ST_EXEC:
            begin
                if (dec.kind == scro_pkg::SCRO_K_PUSH && q_r == `SCRO_Q_PUSH)
                begin
                    stk_cmd.push = 1'b1;
                    stk_cmd.data = pc_r + `SCRO_PC_STEP;
                end
                if (dec.kind == scro_pkg::SCRO_K_CALL && q_r == `SCRO_Q_PUSH)
                begin
                    stk_cmd.push = 1'b1;
                    stk_cmd.data = pc_r + `SCRO_PC_STEP;
                end
                if (dec.kind == scro_pkg::SCRO_K_POP && q_r == `SCRO_Q_POP)
                    stk_cmd.pop = 1'b1;
                if (dec.kind == scro_pkg::SCRO_K_RST && q_r == `SCRO_Q_RST)
                begin
                    state_nxt   = scro_pkg::SCRO_ST_RST;
                    q_nxt       = 2'h0;
                    rst_out_nxt = 1'b1;
                end
                else if (q_r == `SCRO_Q_PC)
                begin
                    ret_nxt = 1'b1;
                    if (dec.kind == scro_pkg::SCRO_K_CALL)
                    begin
                        pc_nxt    = pc_r + `SCRO_PC_STEP + scro_rel(dec.offset);
                        state_nxt = scro_pkg::SCRO_ST_FLUSH;
                    end
                    else
                    begin
                        pc_nxt    = pc_r + `SCRO_PC_STEP;
                        state_nxt = scro_pkg::SCRO_ST_IDLE;
                        ready_nxt = 1'b1;
                    end
                end
            end
            scro_pkg::SCRO_ST_FLUSH:
            begin
                // second cycle of the call is a no-operation
                if (q_r == `SCRO_Q_PC)
                begin
                    state_nxt = scro_pkg::SCRO_ST_IDLE;
                    ready_nxt = 1'b1;
                end
            end
            scro_pkg::SCRO_ST_RST:
            begin
                // same effect as master clear: pc, stack and sequencer cleared
                stk_clr     = 1'b1;
                pc_nxt      = `SCRO_PC_RST;
                ir_nxt      = '0;
                rst_out_nxt = 1'b1;
                if (q_r == `SCRO_Q_PC)
                begin
                    state_nxt   = scro_pkg::SCRO_ST_IDLE;
                    rst_out_nxt = 1'b0;
                    ready_nxt   = 1'b1;
                end
            end
            default:
            begin
                state_nxt = scro_pkg::SCRO_ST_IDLE;
                q_nxt     = 2'h0;
            end
        endcase
        if (!master_clear_input_b_i)
        begin
            state_nxt   = scro_pkg::SCRO_ST_IDLE;
            q_nxt       = 2'h0;
            pc_nxt      = `SCRO_PC_RST;
            ir_nxt      = '0;
            ready_nxt   = 1'b0;
            rst_out_nxt = 1'b1;
            ret_nxt     = 1'b0;
            stk_clr     = 1'b1;
            stk_cmd     = '0;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            state_r   <= scro_pkg::SCRO_ST_IDLE;
            q_r       <= 2'h0;
            ir_r      <= 16'h0000;
            pc_r      <= `SCRO_PC_RST;
            ready_r   <= 1'b0;
            rst_out_r <= 1'b1;
            ret_r     <= 1'b0;
            top_r     <= '0;
            depth_r   <= '0;
        end
        else
        begin
            state_r   <= state_nxt;
            q_r       <= q_nxt;
            ir_r      <= ir_nxt;
            pc_r      <= pc_nxt;
            ready_r   <= ready_nxt;
            rst_out_r <= rst_out_nxt;
            ret_r     <= ret_nxt;
            top_r     <= stk_top;
            depth_r   <= stk_depth;
        end
    end

    // ==========================================================
    // return stack
    scro_stack u_stack
    (
        .ref_clk_i (ref_clk_i),
        .rst_b_i   (rst_b_i),
        .clr_i     (stk_clr),
        .cmd_i     (stk_cmd),
        .top_o     (stk_top),
        .depth_o   (stk_depth)
    );

    assign instr_ready_o     = ready_r;
    assign pc_o              = pc_r;
    assign stack_top_entry_o = top_r;
    assign stack_depth_o     = depth_r;
    assign quarter_o         = q_r;
    assign core_reset_o      = rst_out_r;
    assign retired_o         = ret_r;

    // ==========================================================
    // checks
    pop_one_level_a : assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        stk_cmd.pop && stk_depth != '0 && master_clear_input_b_i
        |=> stk_depth == $past(stk_depth) - 5'h01)
        else $error("pop did not drop one level");

    push_value_a : assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        stk_cmd.push && dec.kind == scro_pkg::SCRO_K_PUSH && master_clear_input_b_i
        |=> stk_top == $past(pc_r) + `SCRO_PC_STEP)
        else $error("push did not store pc plus two");

    push_quarter_a : assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        stk_cmd.push |-> q_r == `SCRO_Q_PUSH)
        else $error("stack write outside second quarter");

    call_two_cycles_a : assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        state_r == scro_pkg::SCRO_ST_EXEC && dec.kind == scro_pkg::SCRO_K_CALL
        && q_r == `SCRO_Q_PC && master_clear_input_b_i
        |=> state_r == scro_pkg::SCRO_ST_FLUSH [*4] ##1 ready_r)
        else $error("call did not take two cycles");

    call_target_a : assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        state_r == scro_pkg::SCRO_ST_EXEC && dec.kind == scro_pkg::SCRO_K_CALL
        && q_r == `SCRO_Q_PC && master_clear_input_b_i
        |=> pc_r == $past(pc_r) + `SCRO_PC_STEP + scro_rel($past(dec.offset)))
        else $error("call target wrong");

    offset_sign_a : assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        dec.kind == scro_pkg::SCRO_K_CALL
        |-> (ir_r[10] ? scro_rel(dec.offset) >= 21'h1FF800 : scro_rel(dec.offset) <= 21'h0007FE))
        else $error("offset sign lost");

    swreset_clears_a : assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        state_r == scro_pkg::SCRO_ST_RST |=> pc_r == `SCRO_PC_RST && stk_depth == '0)
        else $error("software reset left state");

    swreset_q2_a : assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        state_r == scro_pkg::SCRO_ST_EXEC && dec.kind == scro_pkg::SCRO_K_RST
        && q_r == `SCRO_Q_RST && master_clear_input_b_i
        |=> core_reset_o && state_r == scro_pkg::SCRO_ST_RST)
        else $error("software reset not started in Q2");

    nop_quiet_a : assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        state_r == scro_pkg::SCRO_ST_EXEC && dec.kind == scro_pkg::SCRO_K_NOP
        |-> !stk_cmd.push && !stk_cmd.pop)
        else $error("nop touched the stack");

    call_cov_c  : cover property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        state_r == scro_pkg::SCRO_ST_FLUSH);
    rst_cov_c   : cover property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        state_r == scro_pkg::SCRO_ST_RST);
    push_cov_c  : cover property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        stk_cmd.push ##[1:20] stk_cmd.pop);

endmodule : scro_core

// ===== core/scro_stack.sv
// return stack in flip-flops with push/pop and top-entry view
`timescale 1ns/1ps
`include "scro_defs.svh"

module scro_stack
(
    input  wire logic                     ref_clk_i,
    input  wire logic                     rst_b_i,
    input  wire logic                     clr_i,
    input  wire scro_pkg::scro_stk_cmd_t  cmd_i,
    output logic [`SCRO_PC_W-1:0]         top_o,
    output logic [`SCRO_PTR_W-1:0]        depth_o
);

    logic [`SCRO_PC_W-1:0]  mem_r   [`SCRO_STK_DEPTH];
    logic [`SCRO_PC_W-1:0]  mem_nxt [`SCRO_STK_DEPTH];
    logic [`SCRO_PTR_W-1:0] ptr_r;
    logic [`SCRO_PTR_W-1:0] ptr_nxt;

    // ==========================================================
    // next state
    always_comb
    begin
        mem_nxt = mem_r;
        ptr_nxt = ptr_r;
        if (clr_i)
        begin
            ptr_nxt = '0;
        end
        else if (cmd_i.push)
        begin
            // overflow holds the pointer and overwrites the top entry; no trap is modelled
            if (ptr_r != `SCRO_PTR_W'(`SCRO_STK_DEPTH))
                ptr_nxt = ptr_r + 5'h01;
            mem_nxt[ptr_nxt == '0 ? 5'h00 : ptr_nxt - 5'h01] = cmd_i.data;
        end
        else if (cmd_i.pop && ptr_r != '0)
        begin
            ptr_nxt = ptr_r - 5'h01;
        end
    end

    // ==========================================================
    // registers
    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            ptr_r <= '0;
            for (int i = 0; i < `SCRO_STK_DEPTH; i++)
                mem_r[i] <= '0;
        end
        else
        begin
            ptr_r <= ptr_nxt;
            mem_r <= mem_nxt;
        end
    end

    assign top_o   = (ptr_r == '0) ? '0 : mem_r[ptr_r - 5'h01];
    assign depth_o = ptr_r;

endmodule : scro_stack

// ===== shared/scro_defs.svh
// offsets, opcodes and timing constants of the stack/call/reset decoder
`ifndef SCRO_DEFS_SVH
`define SCRO_DEFS_SVH

`define SCRO_OP_POP        16'h0006
`define SCRO_OP_PUSH       16'h0005
`define SCRO_OP_SWRST      16'h00FF
`define SCRO_OP_ZERO       16'h0000
`define SCRO_CALL_MSB      15
`define SCRO_CALL_LSB      11
`define SCRO_CALL_CODE     5'h1B
`define SCRO_NOP_CODE      4'hF
`define SCRO_OFS_W         11
`define SCRO_PC_W          21
`define SCRO_STK_DEPTH     31
`define SCRO_PTR_W         5
`define SCRO_PC_STEP       21'h000002
`define SCRO_PC_RST        21'h000000
`define SCRO_QUARTERS      4
`define SCRO_Q_PUSH        2'h1
`define SCRO_Q_POP         2'h2
`define SCRO_Q_RST         2'h1
`define SCRO_Q_PC          2'h3

`endif

// ===== shared/scro_pkg.sv
// types of the stack/call/reset decoder
package scro_pkg;

    typedef enum logic [3:0] {
        SCRO_ST_EXEC  = 4'h1,
        SCRO_ST_FLUSH = 4'h2,
        SCRO_ST_RST   = 4'h4,
        SCRO_ST_IDLE  = 4'h8
    } scro_state_t;

    typedef enum logic [2:0] {
        SCRO_K_NOP   = 3'h0,
        SCRO_K_POP   = 3'h1,
        SCRO_K_PUSH  = 3'h2,
        SCRO_K_CALL  = 3'h3,
        SCRO_K_RST   = 3'h4,
        SCRO_K_OTHER = 3'h5
    } scro_kind_t;

    typedef struct packed {
        scro_kind_t  kind;
        logic [10:0] offset;
    } scro_dec_t;

    typedef struct packed {
        logic        push;
        logic        pop;
        logic [20:0] data;
    } scro_stk_cmd_t;

endpackage : scro_pkg

// ===== tb/scro_tb.sv
// self-checking bench of the stack/call/reset decoder
`timescale 1ns/1ps
`include "scro_defs.svh"

module tb;
    logic                   ref_clk_i;
    logic                   rst_b_i;
    logic                   master_clear_input_b_i;
    logic [15:0]            instr_i;
    logic                   instr_valid_i;
    logic                   instr_ready_o;
    logic [`SCRO_PC_W-1:0]  pc_o;
    logic [`SCRO_PC_W-1:0]  stack_top_entry_o;
    logic [`SCRO_PTR_W-1:0] stack_depth_o;
    logic [1:0]             quarter_o;
    logic                   core_reset_o;
    logic                   retired_o;
    logic [46:0]            exp_q[$];
    logic [20:0]            stk_m[$];
    logic [20:0]            pc_m;
    logic                   armed;
    logic                   rst_prev;
    int                     fail_count;
    int                     checked;

    scro_core dut
    (
        .ref_clk_i              (ref_clk_i),
        .rst_b_i                (rst_b_i),
        .master_clear_input_b_i (master_clear_input_b_i),
        .instr_i                (instr_i),
        .instr_valid_i          (instr_valid_i),
        .instr_ready_o          (instr_ready_o),
        .pc_o                   (pc_o),
        .stack_top_entry_o      (stack_top_entry_o),
        .stack_depth_o          (stack_depth_o),
        .quarter_o              (quarter_o),
        .core_reset_o           (core_reset_o),
        .retired_o              (retired_o)
    );

    // ==========================================================
    // clock, comparisons, closing
    initial
    begin
        ref_clk_i = 1'b0;
        forever #2 ref_clk_i = ~ref_clk_i;
    end

    task automatic fail_msg(input string msg);
        fail_count++;
        $display("wrong value at %0t: %s", $time, msg);
    endtask : fail_msg

    task automatic check_state(input logic [46:0] exp, input logic [46:0] got);
        checked++;
        if (got !== exp)
            fail_msg($sformatf("pc/top/depth %h expected %h", got, exp));
    endtask : check_state

    task automatic check_cnt(input int exp, input int got);
        checked++;
        if (got != exp)
            fail_msg($sformatf("count %0d expected %0d", got, exp));
    endtask : check_cnt

    task automatic check_q(input logic [1:0] exp, input logic [1:0] got);
        checked++;
        if (got !== exp)
            fail_msg($sformatf("quarter %0d expected %0d", got, exp));
    endtask : check_q

    task automatic end_sim;
        $display("checks %0d, mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : end_sim

    // ==========================================================
    // model notes and instruction driver
    task automatic note;
        exp_q.push_back({pc_m, (stk_m.size() > 0) ? stk_m[$] : 21'h000000,
                         5'(stk_m.size())});
    endtask : note

    task automatic exec(input logic [15:0] w);
        int          n;
        int          r;
        logic [10:0] ofs;
        n = 0;
        while (instr_ready_o !== 1'b1 && n < 100)
        begin
            @(negedge ref_clk_i);
            n++;
        end
        instr_i       = w;
        instr_valid_i = 1'b1;
        @(negedge ref_clk_i);
        instr_valid_i = 1'b0;
        instr_i       = ~w;
        ofs           = w[10:0];
        if (w[`SCRO_CALL_MSB:`SCRO_CALL_LSB] == `SCRO_CALL_CODE)
        begin
            stk_m.push_back(pc_m + `SCRO_PC_STEP);
            pc_m = pc_m + `SCRO_PC_STEP + {{9{ofs[10]}}, ofs, 1'b0};
        end
        else if (w == `SCRO_OP_SWRST)
        begin
            pc_m = `SCRO_PC_RST;
            stk_m.delete();
        end
        else
        begin
            if (w == `SCRO_OP_PUSH)
                stk_m.push_back(pc_m + `SCRO_PC_STEP);
            if (w == `SCRO_OP_POP && stk_m.size() > 0)
                void'(stk_m.pop_back());
            pc_m = pc_m + `SCRO_PC_STEP;
        end
        note();
        check_q(2'h0, quarter_o);
        n = 0;
        r = -1;
        while (instr_ready_o !== 1'b1 && n < 40)
        begin
            @(negedge ref_clk_i);
            n++;
            if (core_reset_o === 1'b1 && r < 0)
                r = n;
        end
        // reset must rise on the second-quarter edge
        if (w == `SCRO_OP_SWRST)
            check_cnt(2, r);
        else
            check_cnt((w[15:11] == `SCRO_CALL_CODE) ? 8 : 4, n);
    endtask : exec

    // one result per retirement or per end of a reset
    always @(negedge ref_clk_i)
    begin
        if (armed && (retired_o === 1'b1 || (rst_prev === 1'b1 && core_reset_o === 1'b0)))
        begin
            if (exp_q.size() == 0)
                fail_msg("result with nothing expected");
            else
                check_state(exp_q.pop_front(), {pc_o, stack_top_entry_o, stack_depth_o});
        end
        rst_prev = core_reset_o;
    end

    // ==========================================================
    // scenarios
    initial
    begin
        logic [15:0] w;
        int          k;
        logic [10:0] ofs_l [4];
        rst_b_i = 1'b0;
        master_clear_input_b_i = 1'b1;
        instr_i = 16'h0000;
        instr_valid_i = 1'b0;
        armed = 1'b0;
        rst_prev = 1'b0;
        fail_count = 0;
        checked = 0;
        pc_m = `SCRO_PC_RST;
        void'($urandom(32'h0CA8));
        repeat (8) @(negedge ref_clk_i);
        rst_b_i = 1'b1;
        // arm late so the release of power-on reset is not taken as a result
        repeat (2) @(negedge ref_clk_i);
        armed = 1'b1;
        exec(`SCRO_OP_POP);
        exec(`SCRO_OP_ZERO);
        exec(`SCRO_OP_PUSH);
        exec(`SCRO_OP_PUSH);
        exec(`SCRO_OP_POP);
        ofs_l = '{11'h3FF, 11'h400, 11'h000, 11'h7FF};
        foreach (ofs_l[i])
            exec({`SCRO_CALL_CODE, ofs_l[i]});
        exec(16'hF123);
        exec(`SCRO_OP_SWRST);
        exec(`SCRO_OP_PUSH);
        pc_m = `SCRO_PC_RST;
        stk_m.delete();
        note();
        master_clear_input_b_i = 1'b0;
        repeat (3) @(negedge ref_clk_i);
        master_clear_input_b_i = 1'b1;
        for (int j = 0; j < 40; j++)
        begin
            k = $urandom_range(0, 4);
            w = (k == 0) ? `SCRO_OP_PUSH : (k == 1) ? `SCRO_OP_POP :
                (k == 2) ? {`SCRO_CALL_CODE, 11'($urandom)} :
                (k == 3) ? {`SCRO_NOP_CODE, 12'($urandom)} : `SCRO_OP_ZERO;
            // keep clear of the full stack, whose overwrite is not modelled
            if (stk_m.size() >= 30 && (k == 0 || k == 2))
                w = `SCRO_OP_POP;
            exec(w);
        end
        exec(`SCRO_OP_SWRST);
        exec(`SCRO_OP_ZERO);
        repeat (20) @(negedge ref_clk_i);
        check_cnt(0, exp_q.size());
        end_sim();
    end

    initial
    begin
        repeat (20000) @(posedge ref_clk_i);
        fail_msg("watchdog expired");
        end_sim();
    end
endmodule : tb
